/* File: jfa_pkg.sv */
package jfa_pkg;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ALARM_STATUS = 8'h04;
  localparam logic [7:0] REG_ALARM_MASK = 8'h08;
  localparam logic [7:0] REG_LANE_FIFO = 8'h0c;
  localparam logic [7:0] REG_LINK_STATUS = 8'h10;

  // Control register fields
  localparam int CTRL_LINK_EN = 0;
  localparam int CTRL_SYNC_HEADER_MODE_SELECT_LO = 1;
  localparam int CTRL_ENC_8B10B = 3;
  localparam int CTRL_CAL_SEL = 4;
  localparam int CTRL_PE_LO = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Sync header mode encodings
  localparam logic [1:0] SYNC_HEADER_MODE_SELECT_CRC12 = 2'h0;
  localparam logic [1:0] SYNC_HEADER_MODE_SELECT_FEC = 2'h2;

  // Alarm status bit positions
  localparam int ALM_CPLL = 0;
  localparam int ALM_SPLL = 1;
  localparam int ALM_NOT_DATA = 2;
  localparam int ALM_SYSREF = 3;
  localparam int ALM_CLK_UPSET = 4;
  localparam int ALM_NUM = 5;
  localparam logic [ALM_NUM-1:0] ALARM_MASK_BITS_RESET = 5'h1f;

  // Link status fields
  localparam int STAT_SUMMARY = 0;
  localparam int STAT_IN_DATA = 1;
  localparam int STAT_CTR_LO = 16;

  // Block and FEC geometry
  localparam int BLK_BITS = 64;
  localparam int BLK_PER_MB = 32;
  localparam int FEC_BITS = 26;
  localparam logic [25:0] FEC_POLY = 26'h0220211;
  localparam int SHS_EOEMB = 22;
  localparam int SHS_LAST = 31;
  localparam logic [1:0] SH_ONE = 2'h1;
  localparam logic [1:0] SH_ZERO = 2'h2;

endpackage

/* File: jfa_fec_if.sv */
`timescale 1ns/1ps
interface jfa_fec_if;
  logic take;
  logic first;
  logic last;
  logic [jfa_pkg::BLK_BITS-1:0] data;
  logic [jfa_pkg::FEC_BITS-1:0] parity;
  logic parity_vld;

  modport src (output take, output first, output last, output data,
               input parity, input parity_vld);
  modport enc (input take, input first, input last, input data,
               output parity, output parity_vld);
endinterface

/* File: jfa_fec_enc.sv */
`timescale 1ns/1ps
module jfa_fec_enc (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Block stream and parity
  jfa_fec_if.enc fec
);

  logic [jfa_pkg::FEC_BITS-1:0] state_r;
  logic [jfa_pkg::FEC_BITS-1:0] state_nxt;
  logic [jfa_pkg::FEC_BITS-1:0] parity_r;
  logic parity_vld_r;

  // Bit-serial division unrolled over one block, first bit is data[63]
  always_comb begin
    logic fb;
    fb = 1'b0;
    state_nxt = fec.first ? '0 : state_r;
    for (int i = jfa_pkg::BLK_BITS - 1; i >= 0; i--) begin
      fb = state_nxt[jfa_pkg::FEC_BITS-1] ^ fec.data[i];
      state_nxt = {state_nxt[jfa_pkg::FEC_BITS-2:0], 1'b0} ^
                  (fb ? jfa_pkg::FEC_POLY : '0);
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= '0;
    end else if (fec.take) begin
      state_r <= state_nxt;
    end
  end

  // Remainder after the 32nd block is the parity word
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      parity_r <= '0;
      parity_vld_r <= 1'b0;
    end else begin
      parity_vld_r <= fec.take & fec.last;
      if (fec.take && fec.last) begin
        parity_r <= state_nxt;
      end
    end
  end

  assign fec.parity = parity_r;
  assign fec.parity_vld = parity_vld_r;

endmodule

/* File: jfa_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - Encoder consumes 32 scrambled 64-bit blocks per multiblock, yields 26 parity bits.
// - Data plus parity form the shortened (2074, 2048) cyclic code.
// - Divide by x^26+x^21+x^17+x^9+x^4+1 to get parity.
// - Clear divider before each multiblock; headers excluded; read after 2048 bits.
// - Link enable low holds link in reset, serializers down, clocks gated.
// - Captured SYSREF resets the local multiframe or extended multiblock clock.
// - Without SYSREF the local clock free-runs; SYNC still starts 8B/10B.
// - Six alarm sources: two PLLs, link state, SYSREF realign, upset, FIFO.
// - Each alarm sets its own sticky bit, cleared by writing 1.
// - Unmasked alarms form a summary; calibration pin can show it.
// - Channel clock mismatch in one system clock sample sets sticky upset flag.
// - Lane FIFO pointer upset sets lane flag; enable toggle resets FIFO.
// - Parity of one multiblock travels in the next multiblock's stream.
// - Sync header mode 2 selects FEC framing of the stream.
// - Stream ends 00001; bit 22 carries end-of-extended-multiblock.
// - Header 01 sends a 1, header 10 sends a 0.
module jfa_top #(
  parameter int LANES = 8,
  parameter int MB_PER_EMB = 1,
  parameter int FRAMES_PER_MF = 32
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Scrambled block stream in
  input wire logic blk_valid_i,
  input wire logic [63:0] blk_data_i,
  // Coded block stream out
  output logic blk_valid_o,
  output logic [63:0] blk_data_o,
  output logic [1:0] sync_hdr_o,
  // Timing pins
  input wire logic sysref_i,
  input wire logic sync_n_i,
  // Alarm sources
  input wire logic conv_pll_locked_i,
  input wire logic ser_pll_locked_i,
  input wire logic chan_a_clk_i,
  input wire logic chan_b_clk_i,
  input wire logic [LANES-1:0] lane_fifo_err_i,
  input wire logic cal_done_i,
  // Link control outputs
  output logic link_reset_o,
  output logic serializer_powerdown_o,
  output logic link_clk_enable_o,
  output logic ser_fifo_reset_o,
  output logic cgs_ilas_start_o,
  output logic lemc_edge_o,
  output logic [3:0] serializer_preemphasis_level_o,
  output logic summary_alarm_o,
  output logic calibration_status_pin_o
);

  localparam int EMB_BLOCKS = jfa_pkg::BLK_PER_MB * MB_PER_EMB;
  localparam int CTR_MAX = (EMB_BLOCKS > FRAMES_PER_MF) ?
                           EMB_BLOCKS : FRAMES_PER_MF;
  localparam int CW = $clog2(CTR_MAX + 1);
  localparam int NSYNC = LANES + 6;

  if (LANES < 1 || LANES > 16 || MB_PER_EMB < 1 || FRAMES_PER_MF < 1) begin
    $error("jfa_top: unsupported parameter values");
  end

  jfa_fec_if fec_bus ();

  // Control, alarm mask, alarm status and lane FIFO registers, read data
  logic link_enable_r;
  logic [1:0] sync_header_mode_select_r;
  logic enc_8b10b_r;
  logic cal_status_sel_r;
  logic [3:0] serializer_preemphasis_level_r;
  logic [jfa_pkg::ALM_NUM-1:0] alarm_status_flags_r;
  logic [jfa_pkg::ALM_NUM-1:0] alarm_mask_bits_r;
  logic [LANES-1:0] lane_fifo_error_flags_r;
  logic [31:0] rdata_r;

  // Synchronisers for every pin input except cal_done_i
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  logic sysref_d_r;
  logic sysref_s;
  logic sync_n_s;
  logic cpll_s;
  logic spll_s;
  logic clka_s;
  logic clkb_s;
  logic [LANES-1:0] fifo_err_s;

  // Local clock counter and stream state
  logic [CW-1:0] ctr_r;
  logic [CW-1:0] period_m1;
  logic sysref_edge;
  logic realign;
  logic [4:0] blk_idx;
  logic eoemb;
  logic shs_bit;
  logic in_data;
  logic blk_valid_r;
  logic [63:0] blk_data_r;
  logic [1:0] sync_hdr_r;
  logic [jfa_pkg::ALM_NUM-1:0] alarm_set;
  logic wr_alarm;
  logic wr_fifo;

  assign pin_raw = {fifo_err_i_view(lane_fifo_err_i), chan_b_clk_i,
                    chan_a_clk_i, ser_pll_locked_i, conv_pll_locked_i,
                    sync_n_i, sysref_i};

  function automatic logic [LANES-1:0] fifo_err_i_view(
    input logic [LANES-1:0] v
  );
    return v;
  endfunction

  // Two flops per pin; only the second stage is read by logic
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pin_raw;
      sync_r <= meta_r;
    end
  end

  assign sysref_s = sync_r[0];
  assign sync_n_s = sync_r[1];
  assign cpll_s = sync_r[2];
  assign spll_s = sync_r[3];
  assign clka_s = sync_r[4];
  assign clkb_s = sync_r[5];
  assign fifo_err_s = sync_r[NSYNC-1:6];

  // Register writes
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      link_enable_r <= jfa_pkg::CTRL_RESET[jfa_pkg::CTRL_LINK_EN];
      sync_header_mode_select_r <=
        jfa_pkg::CTRL_RESET[jfa_pkg::CTRL_SYNC_HEADER_MODE_SELECT_LO +: 2];
      enc_8b10b_r <= jfa_pkg::CTRL_RESET[jfa_pkg::CTRL_ENC_8B10B];
      cal_status_sel_r <= jfa_pkg::CTRL_RESET[jfa_pkg::CTRL_CAL_SEL];
      serializer_preemphasis_level_r <=
        jfa_pkg::CTRL_RESET[jfa_pkg::CTRL_PE_LO +: 4];
    end else if (reg_wr_i && reg_addr_i == jfa_pkg::REG_CTRL) begin
      // Link settings are only safe to change while disabled
      link_enable_r <= reg_wdata_i[jfa_pkg::CTRL_LINK_EN];
      sync_header_mode_select_r <= reg_wdata_i[jfa_pkg::CTRL_SYNC_HEADER_MODE_SELECT_LO +: 2];
      enc_8b10b_r <= reg_wdata_i[jfa_pkg::CTRL_ENC_8B10B];
      cal_status_sel_r <= reg_wdata_i[jfa_pkg::CTRL_CAL_SEL];
      serializer_preemphasis_level_r <= reg_wdata_i[jfa_pkg::CTRL_PE_LO +: 4];
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      alarm_mask_bits_r <= jfa_pkg::ALARM_MASK_BITS_RESET;
    end else if (reg_wr_i && reg_addr_i == jfa_pkg::REG_ALARM_MASK) begin
      alarm_mask_bits_r <= reg_wdata_i[jfa_pkg::ALM_NUM-1:0];
    end
  end

  // Link enable gating
  assign link_reset_o = ~link_enable_r;
  assign serializer_powerdown_o = ~link_enable_r;
  assign link_clk_enable_o = link_enable_r;
  assign ser_fifo_reset_o = ~link_enable_r;
  assign serializer_preemphasis_level_o = serializer_preemphasis_level_r;

  // SYSREF capture and local clock
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sysref_d_r <= 1'b0;
    end else begin
      sysref_d_r <= sysref_s;
    end
  end

  assign sysref_edge = sysref_s & ~sysref_d_r;
  assign period_m1 = enc_8b10b_r ? CW'(FRAMES_PER_MF - 1) :
                                   CW'(EMB_BLOCKS - 1);
  assign realign = sysref_edge && link_enable_r && ctr_r != '0;

  // Counter advances per block or frame strobe; free-runs without SYSREF
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ctr_r <= '0;
    end else if (!link_enable_r) begin
      ctr_r <= '0;
    end else if (sysref_edge) begin
      ctr_r <= '0;
    end else if (blk_valid_i) begin
      ctr_r <= (ctr_r == period_m1) ? '0 : ctr_r + 1'b1;
    end
  end

  assign lemc_edge_o = link_enable_r && ctr_r == '0;
  assign blk_idx = ctr_r[4:0];
  assign eoemb = (ctr_r >> 5) == CW'(MB_PER_EMB - 1);

  // FEC divider fed with each block in transmission order
  assign fec_bus.take = blk_valid_i & link_enable_r & ~enc_8b10b_r;
  assign fec_bus.first = blk_idx == 5'h00;
  assign fec_bus.last = blk_idx == 5'h1f;
  assign fec_bus.data = blk_data_i;

  jfa_fec_enc u_fec (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .fec(fec_bus)
  );

  // Sync header stream bit for a block position
  function automatic logic shs_map(
    input logic [4:0] idx,
    input logic [25:0] par,
    input logic eo,
    input logic [1:0] mode
  );
    logic b;
    b = 1'b0;
    if (idx == 5'(jfa_pkg::SHS_EOEMB)) begin
      b = eo;
    end else if (idx == 5'(jfa_pkg::SHS_LAST)) begin
      b = 1'b1;
    end else if (idx > 5'd26) begin
      b = 1'b0;
    end else if (mode == jfa_pkg::SYNC_HEADER_MODE_SELECT_FEC) begin
      // Parity of the previous multiblock, MSB first
      b = (idx < 5'd22) ? par[5'd25 - idx] : par[5'd26 - idx];
    end else begin
      // Other modes keep the pilot ones; CRC content is not produced here
      b = (idx[1:0] == 2'h3) || idx == 5'd21;
    end
    return b;
  endfunction

  assign shs_bit = shs_map(blk_idx, fec_bus.parity, eoemb,
                           sync_header_mode_select_r);

  // Output stage
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      blk_valid_r <= 1'b0;
      blk_data_r <= '0;
      sync_hdr_r <= jfa_pkg::SH_ZERO;
    end else begin
      blk_valid_r <= blk_valid_i & link_enable_r & ~enc_8b10b_r;
      if (blk_valid_i) begin
        blk_data_r <= blk_data_i;
        sync_hdr_r <= shs_bit ? jfa_pkg::SH_ONE : jfa_pkg::SH_ZERO;
      end
    end
  end

  assign blk_valid_o = blk_valid_r;
  assign blk_data_o = blk_data_r;
  assign sync_hdr_o = sync_hdr_r;

  // 8B/10B start of code group sync follows SYNC even without SYSREF
  assign cgs_ilas_start_o = link_enable_r & enc_8b10b_r & ~sync_n_s;
  assign in_data = link_enable_r & (~enc_8b10b_r | sync_n_s);

  // Alarm sources; upset compares the synchronised channel clocks every cycle
  always_comb begin
    alarm_set = '0;
    alarm_set[jfa_pkg::ALM_CPLL] = ~cpll_s;
    alarm_set[jfa_pkg::ALM_SPLL] = ~spll_s;
    alarm_set[jfa_pkg::ALM_NOT_DATA] = ~in_data;
    alarm_set[jfa_pkg::ALM_SYSREF] = realign;
    alarm_set[jfa_pkg::ALM_CLK_UPSET] = clka_s ^ clkb_s;
  end

  assign wr_alarm = reg_wr_i && reg_addr_i == jfa_pkg::REG_ALARM_STATUS;
  assign wr_fifo = reg_wr_i && reg_addr_i == jfa_pkg::REG_LANE_FIFO;

  // Sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      alarm_status_flags_r <= '0;
    end else begin
      alarm_status_flags_r <= (alarm_status_flags_r &
        ~(wr_alarm ? reg_wdata_i[jfa_pkg::ALM_NUM-1:0] : '0)) |
        alarm_set;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      lane_fifo_error_flags_r <= '0;
    end else begin
      lane_fifo_error_flags_r <= (lane_fifo_error_flags_r &
        ~(wr_fifo ? reg_wdata_i[LANES-1:0] : '0)) |
        (fifo_err_s & {LANES{link_enable_r}});
    end
  end

  assign summary_alarm_o = |(alarm_status_flags_r & ~alarm_mask_bits_r) |
                           |lane_fifo_error_flags_r;
  assign calibration_status_pin_o = cal_status_sel_r ? summary_alarm_o :
                                    cal_done_i;

  // Register reads, data in the following cycle only
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          jfa_pkg::REG_CTRL: begin
            rdata_r[jfa_pkg::CTRL_LINK_EN] <= link_enable_r;
            rdata_r[jfa_pkg::CTRL_SYNC_HEADER_MODE_SELECT_LO +: 2] <=
              sync_header_mode_select_r;
            rdata_r[jfa_pkg::CTRL_ENC_8B10B] <= enc_8b10b_r;
            rdata_r[jfa_pkg::CTRL_CAL_SEL] <= cal_status_sel_r;
            rdata_r[jfa_pkg::CTRL_PE_LO +: 4] <=
              serializer_preemphasis_level_r;
          end
          jfa_pkg::REG_ALARM_STATUS: begin
            rdata_r[jfa_pkg::ALM_NUM-1:0] <= alarm_status_flags_r;
          end
          jfa_pkg::REG_ALARM_MASK: begin
            rdata_r[jfa_pkg::ALM_NUM-1:0] <= alarm_mask_bits_r;
          end
          jfa_pkg::REG_LANE_FIFO: begin
            rdata_r[LANES-1:0] <= lane_fifo_error_flags_r;
          end
          jfa_pkg::REG_LINK_STATUS: begin
            rdata_r[jfa_pkg::STAT_SUMMARY] <= summary_alarm_o;
            rdata_r[jfa_pkg::STAT_IN_DATA] <= in_data;
            rdata_r[jfa_pkg::STAT_CTR_LO +: CW] <= ctr_r;
          end
          default: begin
            rdata_r <= '0;
          end
        endcase
      end
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule

/* File: jfa_chk.sv */
`timescale 1ns/1ps
module jfa_chk #(
  parameter int LANES = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Register strobes
  input wire logic reg_wr_i,
  // Block streams
  input wire logic blk_valid_i,
  input wire logic [63:0] blk_data_i,
  input wire logic blk_valid_o,
  input wire logic [63:0] blk_data_o,
  input wire logic [1:0] sync_hdr_o,
  // Pins and alarm sources
  input wire logic sysref_i,
  input wire logic [LANES-1:0] lane_fifo_err_i,
  input wire logic cal_done_i,
  // Link control and alarm outputs
  input wire logic link_reset_o,
  input wire logic serializer_powerdown_o,
  input wire logic link_clk_enable_o,
  input wire logic ser_fifo_reset_o,
  input wire logic cgs_ilas_start_o,
  input wire logic lemc_edge_o,
  input wire logic summary_alarm_o,
  input wire logic calibration_status_pin_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  property p_off_outputs;
    link_reset_o |-> serializer_powerdown_o && !link_clk_enable_o;
  endproperty
  a_off_outputs: assert property (p_off_outputs) else $error("off state");
  property p_on_outputs;
    !link_reset_o |-> link_clk_enable_o && !ser_fifo_reset_o;
  endproperty
  a_on_outputs: assert property (p_on_outputs) else $error("on state");
  property p_no_blk_off;
    link_reset_o |=> !blk_valid_o;
  endproperty
  a_no_blk_off: assert property (p_no_blk_off) else $error("blk leak");
  property p_hdr_legal;
    sync_hdr_o == 2'h1 || sync_hdr_o == 2'h2;
  endproperty
  a_hdr_legal: assert property (p_hdr_legal) else $error("bad header");
  property p_blk_pass;
    blk_valid_o |-> $past(blk_valid_i) && blk_data_o == $past(blk_data_i);
  endproperty
  a_blk_pass: assert property (p_blk_pass) else $error("blk order");
  property p_sticky;
    $fell(summary_alarm_o) |-> $past(reg_wr_i);
  endproperty
  a_sticky: assert property (p_sticky) else $error("alarm fell alone");
  property p_cal_pin;
    calibration_status_pin_o && !summary_alarm_o |-> cal_done_i;
  endproperty
  a_cal_pin: assert property (p_cal_pin) else $error("cal pin");
  property p_fifo_alarm;
    ((|lane_fifo_err_i) && !link_reset_o) [*2] |-> ##[1:3] summary_alarm_o;
  endproperty
  a_fifo_alarm: assert property (p_fifo_alarm) else $error("fifo alarm");
  // Quiet link needed: any block right after the clear moves the counter
  property p_sysref_edge;
    $rose(sysref_i) && !link_reset_o ##1 (!link_reset_o && !blk_valid_i) [*4]
      |-> lemc_edge_o;
  endproperty
  a_sysref_edge: assert property (p_sysref_edge) else $error("no lemc");
  property p_cgs;
    cgs_ilas_start_o |-> !link_reset_o;
  endproperty
  a_cgs: assert property (p_cgs) else $error("cgs while off");

  c_lemc: cover property (lemc_edge_o && !link_reset_o);
  c_blk: cover property (blk_valid_o);
  c_cal: cover property (calibration_status_pin_o && summary_alarm_o);
endmodule

bind jfa_top jfa_chk #(.LANES(LANES)) jfa_chk_inst (
  .clk_sys_i, .reset_i, .reg_wr_i, .blk_valid_i, .blk_data_i,
  .blk_valid_o, .blk_data_o, .sync_hdr_o, .sysref_i, .lane_fifo_err_i,
  .cal_done_i, .link_reset_o, .serializer_powerdown_o, .link_clk_enable_o,
  .ser_fifo_reset_o, .cgs_ilas_start_o, .lemc_edge_o, .summary_alarm_o,
  .calibration_status_pin_o
);

/* File: jfa_rx_model.sv */
`timescale 1ns/1ps
module jfa_rx_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Coded block stream
  input wire logic blk_valid_i,
  input wire logic [1:0] sync_hdr_i,
  // Collected stream
  output logic [31:0] shs_o,
  output logic [31:0] n_mb_o,
  output logic err_o
);
  logic [31:0] sh_r;
  logic [4:0] pos_r;
  logic bit_w;
  assign bit_w = (sync_hdr_i == 2'h1);
  // Aligned from reset only; a realign of the sender is not followed
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sh_r <= 32'h0;
      pos_r <= 5'h0;
      shs_o <= 32'h0;
      n_mb_o <= 32'h0;
      err_o <= 1'b0;
    end else if (blk_valid_i) begin
      sh_r[pos_r] <= bit_w;
      pos_r <= pos_r + 5'h1;
      if (sync_hdr_i[1] == sync_hdr_i[0]) begin
        err_o <= 1'b1;
      end
      // Release at the multiblock edge itself, zero release delay
      if (pos_r == 5'h1f) begin
        shs_o <= {bit_w, sh_r[30:0]};
        n_mb_o <= n_mb_o + 32'h1;
        // One multiblock per extended multiblock, so every end flag is 1
        if (!bit_w || sh_r[30:27] != 4'h0 || !sh_r[22]) begin
          err_o <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: test_jesd_fec_align_alarm.sv */
`timescale 1ns/1ps
module test_jesd_fec_align_alarm;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, blk_valid_i = 1'b0;
  logic [63:0] blk_data_i = 64'h0;
  logic sysref_i = 1'b0, sync_n_i = 1'b1, conv_pll_locked_i = 1'b1;
  logic ser_pll_locked_i = 1'b1, chan_a_clk_i = 1'b0, chan_b_clk_i = 1'b0;
  logic [7:0] lane_fifo_err_i = 8'h00;
  logic cal_done_i = 1'b0;
  logic [31:0] reg_rdata_o, shs, n_mb, rd_d, exp_s;
  logic [63:0] blk_data_o;
  logic [1:0] sync_hdr_o;
  logic [3:0] pe;
  logic [25:0] par;
  logic blk_valid_o, link_reset_o, serializer_powerdown_o, link_clk_enable_o;
  logic ser_fifo_reset_o, cgs_ilas_start_o, lemc_edge_o, summary_alarm_o;
  logic calibration_status_pin_o, rx_err;
  int errors = 0;
  int n_checks = 0;

  jfa_top jfa_top_inst (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .blk_valid_i, .blk_data_i,
    .blk_valid_o, .blk_data_o, .sync_hdr_o, .sysref_i, .sync_n_i,
    .conv_pll_locked_i, .ser_pll_locked_i, .chan_a_clk_i, .chan_b_clk_i,
    .lane_fifo_err_i, .cal_done_i, .link_reset_o, .serializer_powerdown_o,
    .link_clk_enable_o, .ser_fifo_reset_o, .cgs_ilas_start_o, .lemc_edge_o,
    .serializer_preemphasis_level_o(pe), .summary_alarm_o,
    .calibration_status_pin_o);
  jfa_rx_model jfa_rx_model_inst (.clk_sys_i, .reset_i,
    .blk_valid_i(blk_valid_o), .sync_hdr_i(sync_hdr_o), .shs_o(shs),
    .n_mb_o(n_mb), .err_o(rx_err));

  always #4 clk_sys_i = ~clk_sys_i;

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    rd_d = reg_rdata_o;
    chk(nm, e, rd_d);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  function automatic logic [63:0] blk(input int i);
    logic [31:0] v;
    v = 32'(i);
    return {v * 32'h0101_0107 ^ 32'hc3a5_0f1e, v + 32'h7e15_9a3b};
  endfunction
  // Bit 63 goes first on the wire, so it is divided first
  function automatic logic [25:0] fec_step(input logic [25:0] s,
                                           input logic [63:0] d);
    logic fb;
    for (int b = 63; b >= 0; b--) begin
      fb = d[b] ^ s[25];
      s = {s[24:0], 1'b0} ^ (fb ? 26'h0220211 : 26'h0);
    end
    return s;
  endfunction

  initial begin
    cyc(3);
    reset_i <= 1'b0;
    rd(jfa_pkg::REG_CTRL, 32'h0, "ctrl");
    rd(jfa_pkg::REG_ALARM_MASK, 32'h1f, "mask");
    rd(jfa_pkg::REG_ALARM_STATUS, 32'h7, "alarms");
    rd(8'h40, 32'h0, "unmapped");
    chk("link_reset", 32'h1, link_reset_o);
    wr(jfa_pkg::REG_ALARM_STATUS, 32'h3);
    rd(jfa_pkg::REG_ALARM_STATUS, 32'h4, "w1c");
    $display("done reset and clear");
    chk("summary masked", 32'h0, summary_alarm_o);
    wr(jfa_pkg::REG_ALARM_MASK, 32'h1b);
    wr(jfa_pkg::REG_CTRL, 32'h10);
    chk("cal pin alarm", 32'h1, calibration_status_pin_o);
    wr(jfa_pkg::REG_ALARM_MASK, 32'h1f);
    chk("cal pin idle", 32'h0, calibration_status_pin_o);
    wr(jfa_pkg::REG_CTRL, 32'h0);
    $display("done summary");
    chan_a_clk_i <= 1'b1;
    conv_pll_locked_i <= 1'b0;
    cyc(3);
    chan_a_clk_i <= 1'b0;
    conv_pll_locked_i <= 1'b1;
    cyc(4);
    rd(jfa_pkg::REG_ALARM_STATUS, 32'h15, "upset");
    wr(jfa_pkg::REG_ALARM_STATUS, 32'h11);
    rd(jfa_pkg::REG_ALARM_STATUS, 32'h4, "upset clr");
    $display("done upset");
    wr(jfa_pkg::REG_CTRL, 32'h1);
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_sys_i);
      blk_valid_i <= 1'b1;
    end
    @(posedge clk_sys_i);
    blk_valid_i <= 1'b0;
    cyc(3);
    chk("crc pilots", 32'h80e8_8888, shs);
    wr(jfa_pkg::REG_CTRL, 32'h0);
    $display("done crc");
    wr(jfa_pkg::REG_CTRL, 32'h4);
    wr(jfa_pkg::REG_CTRL, 32'h5);
    chk("ser on", 32'h0, serializer_powerdown_o);
    chk("clk en", 32'h1, link_clk_enable_o);
    wr(jfa_pkg::REG_ALARM_STATUS, 32'h4);
    rd(jfa_pkg::REG_ALARM_STATUS, 32'h0, "in data");
    par = 26'h0;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_sys_i);
      blk_valid_i <= 1'b1;
      blk_data_i <= blk(i);
      if (i < 32) par = fec_step(par, blk(i));
    end
    @(posedge clk_sys_i);
    blk_valid_i <= 1'b0;
    for (int w = 0; w < 100 && n_mb !== 32'h3; w++) cyc(1);
    if (n_mb !== 32'h3) begin
      errors++;
      complete_run();
    end
    for (int k = 0; k < 32; k++) begin
      exp_s[k] = (k < 22) ? par[25-k] : (k == 22) ? 1'b1 :
                 (k < 27) ? par[26-k] : (k == 31);
    end
    chk("stream", exp_s, shs);
    chk("blk lo", 32'(blk(63)), blk_data_o[31:0]);
    chk("blk hi", 32'(blk(63) >> 32), blk_data_o[63:32]);
    chk("rx err", 32'h0, rx_err);
    $display("done fec");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_i);
      blk_valid_i <= 1'b1;
    end
    @(posedge clk_sys_i);
    blk_valid_i <= 1'b0;
    cyc(2);
    sysref_i <= 1'b1;
    cyc(3);
    sysref_i <= 1'b0;
    cyc(4);
    rd(jfa_pkg::REG_ALARM_STATUS, 32'h8, "sysref");
    rd(jfa_pkg::REG_LINK_STATUS, 32'h2, "status");
    chk("lemc", 32'h1, lemc_edge_o);
    $display("done sysref");
    lane_fifo_err_i <= 8'h01;
    cyc(3);
    lane_fifo_err_i <= 8'h00;
    cyc(3);
    rd(jfa_pkg::REG_LANE_FIFO, 32'h1, "lane fifo");
    chk("fifo summary", 32'h1, summary_alarm_o);
    wr(jfa_pkg::REG_CTRL, 32'h4);
    chk("fifo reset", 32'h1, ser_fifo_reset_o);
    wr(jfa_pkg::REG_LANE_FIFO, 32'h1);
    rd(jfa_pkg::REG_LANE_FIFO, 32'h0, "fifo clr");
    $display("done fifo");
    wr(jfa_pkg::REG_CTRL, 32'h8);
    wr(jfa_pkg::REG_CTRL, 32'h9);
    sync_n_i <= 1'b0;
    cyc(4);
    chk("cgs start", 32'h1, cgs_ilas_start_o);
    sync_n_i <= 1'b1;
    cyc(4);
    chk("cgs stop", 32'h0, cgs_ilas_start_o);
    $display("done sync");
    wr(jfa_pkg::REG_CTRL, 32'h8);
    wr(jfa_pkg::REG_CTRL, 32'ha08);
    chk("preemph", 32'ha, pe);
    rd(jfa_pkg::REG_CTRL, 32'ha08, "ctrl rb");
    $display("done preemph");
    complete_run();
  end
endmodule
